// File: core/sdbc_bus_command.sv
// Status-decoding bus command and control generator.
`timescale 1ns/1ps

module sdbc_bus_command #(
  parameter int GRANT_CYCLES = sdbc_pkg::SDBC_GRANT_CYCLES
) (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  // Processor status pins
  input  wire sdbc_pkg::sdbc_status_t status_i,
  // Strap and qualifiers from the system
  input  wire logic                   io_bus_mode_strap_i,
  input  wire logic                   bus_grant_enable_n_i,
  input  wire logic                   command_qualifier_i,
  // Command strobes and their driver enables
  output logic [$bits(sdbc_pkg::sdbc_cmd_t)-1:0]    cmd_o,
  output logic [$bits(sdbc_pkg::sdbc_cmd_oe_t)-1:0] cmd_oe_o,
  // Control outputs
  output logic                        address_latch_strobe_o,
  output logic                        transceiver_enable_o,
  output logic                        transfer_direction_o,
  output logic                        cascade_or_periph_enable_o
);
  import sdbc_pkg::*;

  // The grant counter must reach its last value. A zero delay would let a
  // command start as soon as the grant has passed the synchroniser, with no wait.
  if (GRANT_CYCLES < 1) begin : g_grant_too_short
    $error("GRANT_CYCLES must be at least one");
  end
  if (GRANT_CYCLES >= (1 << SDBC_GRANT_CNT_W)) begin : g_grant_too_long
    $error("GRANT_CYCLES does not fit the grant counter");
  end

  localparam logic [SDBC_GRANT_CNT_W-1:0] GRANT_LAST =
    SDBC_GRANT_CNT_W'(GRANT_CYCLES);
  localparam sdbc_cmd_t CMD_IDLE = '{default: SDBC_STROBE_IDLE_N};

  typedef struct packed {
    logic [2:0]                  st_sync1;
    logic [2:0]                  st_sync2;
    logic [2:0]                  st_prev;
    logic [2:0]                  st_lat;
    logic [1:0]                  ctl_sync1;
    logic [1:0]                  ctl_sync2;
    logic                        strap_sync1;
    logic                        strap;
    logic [SDBC_GRANT_CNT_W-1:0] grant_cnt;
    sdbc_state_t                 state;
    sdbc_cmd_t                   cmd;
    sdbc_cmd_oe_t                oe;
    logic                        ale;
    logic                        transceiver_enable;
    logic                        dir;
    logic                        cpe;
  } sdbc_regs_t;

  sdbc_regs_t regs_r;
  sdbc_regs_t regs_nxt;

  // Reset state: status passive, grant lost, qualifier low, drivers off.
  localparam sdbc_regs_t REGS_RESET = '{
    st_sync1:    SDBC_ST_PASSIVE,
    st_sync2:    SDBC_ST_PASSIVE,
    st_prev:     SDBC_ST_PASSIVE,
    st_lat:      SDBC_ST_PASSIVE,
    ctl_sync1:   2'h2,
    ctl_sync2:   2'h2,
    strap_sync1: 1'b0,
    strap:       1'b0,
    grant_cnt:   '0,
    state:       SDBC_IDLE,
    cmd:         CMD_IDLE,
    oe:          '0,
    ale:         1'b0,
    transceiver_enable:         1'b0,
    dir:         1'b0,
    cpe:         1'b0
  };

  // Saturating grant counter; it restarts whenever the grant is withdrawn.
  function automatic logic [SDBC_GRANT_CNT_W-1:0] sdbc_grant_step(
    input logic                        lost,
    input logic [SDBC_GRANT_CNT_W-1:0] cnt
  );
    if (lost) begin
      return '0;
    end
    if (cnt == GRANT_LAST) begin
      return cnt;
    end
    return cnt + 1'b1;
  endfunction : sdbc_grant_step

  // First strobes of a cycle: reads, acknowledge and the early writes.
  // Normal writes wait one more clock, which is what gives slow devices
  // their head start on the early write strobes.
  function automatic sdbc_cmd_t sdbc_lead(input sdbc_cmd_t d);
    sdbc_cmd_t c;
    c                          = d;
    c.early_mem_write_strobe_n = d.mem_write_strobe_n;
    c.early_io_write_strobe_n  = d.io_write_strobe_n;
    c.mem_write_strobe_n       = SDBC_STROBE_IDLE_N;
    c.io_write_strobe_n        = SDBC_STROBE_IDLE_N;
    return c;
  endfunction : sdbc_lead

  // Decoded command for one status code, all strobes active low.
  function automatic sdbc_cmd_t sdbc_decode(input logic [2:0] code);
    sdbc_cmd_t c;
    c = CMD_IDLE;
    case (code)
      SDBC_ST_IRQ_ACK: begin
        c.irq_acknowledge_n = 1'b0;
      end
      SDBC_ST_IO_RD: begin
        c.io_read_strobe_n = 1'b0;
      end
      SDBC_ST_IO_WR: begin
        c.io_write_strobe_n = 1'b0;
      end
      SDBC_ST_FETCH,
      SDBC_ST_MEM_RD: begin
        c.mem_read_strobe_n = 1'b0;
      end
      SDBC_ST_MEM_WR: begin
        c.mem_write_strobe_n = 1'b0;
      end
      default: begin
        c = CMD_IDLE;
      end
    endcase
    return c;
  endfunction : sdbc_decode

  function automatic logic sdbc_is_io(input logic [2:0] code);
    return ~code[2] && (code != SDBC_ST_HALT);
  endfunction : sdbc_is_io

  function automatic logic sdbc_is_write(input logic [2:0] code);
    return (code == SDBC_ST_IO_WR) || (code == SDBC_ST_MEM_WR);
  endfunction : sdbc_is_write

  // Peripheral enable is active low and covers I/O-side transfers only.
  function automatic logic sdbc_periph_n(input logic       transceiver_enable,
                                         input logic [2:0] code);
    return !(transceiver_enable && sdbc_is_io(code));
  endfunction : sdbc_periph_n

  logic       st_active;
  logic       st_new;
  logic       granted;
  logic       io_free;
  logic       cmd_ok;
  logic       qual;
  sdbc_cmd_t  dec;

  always_comb begin
    regs_nxt = regs_r;
    // Every pin crosses two flops before use; this costs three clocks
    // between a status change and the latch strobe.
    regs_nxt.st_sync1    = status_i;
    regs_nxt.st_sync2    = regs_r.st_sync1;
    regs_nxt.st_prev     = regs_r.st_sync2;
    regs_nxt.ctl_sync1   = {bus_grant_enable_n_i, command_qualifier_i};
    regs_nxt.ctl_sync2   = regs_r.ctl_sync1;
    regs_nxt.strap_sync1 = io_bus_mode_strap_i;
    regs_nxt.strap       = regs_r.strap_sync1;

    // A cycle starts only on a passive-to-active change, so a code that is
    // held, as in halt, never starts a second cycle.
    st_active = regs_r.st_sync2 != SDBC_ST_PASSIVE;
    st_new    = st_active && (regs_r.st_prev == SDBC_ST_PASSIVE);
    qual      = regs_r.ctl_sync2[0];
    dec       = sdbc_decode(regs_r.st_lat);

    // Grant counter measures the enable delay after grant goes low. The
    // count starts behind the synchroniser, so the true wait is two clocks
    // longer; keep the sum inside the upper bound of the delay.
    regs_nxt.grant_cnt = sdbc_grant_step(regs_r.ctl_sync2[1],
                                         regs_r.grant_cnt);
    granted = (regs_r.grant_cnt == GRANT_LAST) && !regs_r.ctl_sync2[1];
    // I/O on the dedicated bus needs no arbitration.
    io_free = regs_r.strap && sdbc_is_io(regs_r.st_lat);
    cmd_ok  = io_free || granted;

    // Drivers float once grant is lost, except dedicated I/O lines.
    regs_nxt.oe.io_oe  = regs_r.strap || !regs_r.ctl_sync2[1];
    regs_nxt.oe.mem_oe = !regs_r.ctl_sync2[1];

    regs_nxt.ale = 1'b0;
    regs_nxt.cpe = regs_r.strap ? 1'b1 : 1'b0;
    case (regs_r.state)
      SDBC_IDLE: begin
        regs_nxt.cmd = CMD_IDLE;
        regs_nxt.transceiver_enable = 1'b0;
        if (st_new) begin
          // Rises on the clock edge after the synchronised status turns active.
          regs_nxt.ale    = 1'b1;
          regs_nxt.st_lat = regs_r.st_sync2;
          regs_nxt.dir    = sdbc_is_write(regs_r.st_sync2);
          if (!regs_r.strap && regs_r.st_sync2 == SDBC_ST_IRQ_ACK) begin
            regs_nxt.cpe = 1'b1;
          end
          regs_nxt.state = SDBC_LATCH;
        end
      end
      SDBC_LATCH: begin
        if (regs_r.st_lat == SDBC_ST_HALT) begin
          // Halt issues nothing; the cycle only runs out.
          regs_nxt.state = SDBC_FINISH;
        end else if (cmd_ok) begin
          // Reads, acknowledge and early writes assert first.
          regs_nxt.cmd = sdbc_lead(dec);
          regs_nxt.transceiver_enable   = qual;
          regs_nxt.state = SDBC_ACTIVE;
        end
        if (!st_active) begin
          regs_nxt.state = SDBC_FINISH;
        end
      end
      SDBC_ACTIVE: begin
        // Normal writes follow the early ones by one clock.
        regs_nxt.cmd.mem_write_strobe_n = dec.mem_write_strobe_n;
        regs_nxt.cmd.io_write_strobe_n  = dec.io_write_strobe_n;
        regs_nxt.transceiver_enable = qual;
        if (!st_active) begin
          regs_nxt.cmd   = CMD_IDLE;
          regs_nxt.state = SDBC_FINISH;
        end
      end
      SDBC_FINISH: begin
        // Enable drops a full clock after the strobes went idle.
        regs_nxt.cmd   = CMD_IDLE;
        regs_nxt.transceiver_enable   = 1'b0;
        regs_nxt.dir   = 1'b0;
        regs_nxt.state = SDBC_IDLE;
      end
      default: begin
        regs_nxt.cmd   = CMD_IDLE;
        regs_nxt.transceiver_enable   = 1'b0;
        regs_nxt.state = SDBC_IDLE;
      end
    endcase

    // Qualifier low holds strobes driven inactive, not floated. It wins
    // over a lost grant, so a partitioned bus never sees floating lines.
    if (!qual) begin
      regs_nxt.cmd = CMD_IDLE;
      regs_nxt.transceiver_enable = 1'b0;
      regs_nxt.oe  = '{default: 1'b1};
    end
    // Peripheral enable (active low) mirrors data enable for I/O-side cycles in I/O-bus mode.
    if (regs_r.strap) begin
      regs_nxt.cpe = sdbc_periph_n(regs_nxt.transceiver_enable,
                                   regs_nxt.st_lat);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      regs_r <= REGS_RESET;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // Outputs come straight from the state register.
  always_comb begin
    cmd_o                      = regs_r.cmd;
    cmd_oe_o                   = regs_r.oe;
    address_latch_strobe_o     = regs_r.ale;
    transceiver_enable_o       = regs_r.transceiver_enable;
    transfer_direction_o       = regs_r.dir;
    cascade_or_periph_enable_o = regs_r.cpe;
  end

endmodule : sdbc_bus_command

// File: core/sdbc_pkg.sv
// Shared constants, enumerations and carrier types for the bus command block.
package sdbc_pkg;

  // Status codes as seen on the three status inputs (bit two first).
  localparam logic [2:0] SDBC_ST_IRQ_ACK = 3'h0;
  localparam logic [2:0] SDBC_ST_IO_RD   = 3'h1;
  localparam logic [2:0] SDBC_ST_IO_WR   = 3'h2;
  localparam logic [2:0] SDBC_ST_HALT    = 3'h3;
  localparam logic [2:0] SDBC_ST_FETCH   = 3'h4;
  localparam logic [2:0] SDBC_ST_MEM_RD  = 3'h5;
  localparam logic [2:0] SDBC_ST_MEM_WR  = 3'h6;
  localparam logic [2:0] SDBC_ST_PASSIVE = 3'h7;

  // Clock period and bus-grant enable delay window, in nanoseconds.
  localparam int SDBC_CLK_PERIOD_NS = 20;
  localparam int SDBC_GRANT_MIN_NS  = 110;
  localparam int SDBC_GRANT_MAX_NS  = 250;
  // Least time rounds up to whole cycles.
  localparam int SDBC_GRANT_CYCLES  =
    (SDBC_GRANT_MIN_NS + SDBC_CLK_PERIOD_NS - 1) / SDBC_CLK_PERIOD_NS;
  localparam int SDBC_GRANT_CNT_W   = 4;

  // Idle and reset level of the active-low command strobes.
  localparam logic SDBC_STROBE_IDLE_N = 1'b1;

  // Machine-cycle sequencer, Gray coded except for the LATCH-to-FINISH skip.
  typedef enum logic [1:0] {
    SDBC_IDLE   = 2'b00,
    SDBC_LATCH  = 2'b01,
    SDBC_ACTIVE = 2'b11,
    SDBC_FINISH = 2'b10
  } sdbc_state_t;

  // Active-low command strobes.
  typedef struct packed {
    logic mem_read_strobe_n;
    logic mem_write_strobe_n;
    logic early_mem_write_strobe_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic early_io_write_strobe_n;
    logic irq_acknowledge_n;
  } sdbc_cmd_t;

  // Output enables of the command drivers, high while driven.
  typedef struct packed {
    logic mem_oe;
    logic io_oe;
  } sdbc_cmd_oe_t;

  // Status pins as they arrive.
  typedef struct packed {
    logic status_bit_two;
    logic status_bit_one;
    logic status_bit_zero;
  } sdbc_status_t;

endpackage : sdbc_pkg

// File: test/sdbc_bus_command_props.sv
// Port-level checker of the bus command block.
`timescale 1ns/1ps
module sdbc_bus_command_props #(
  parameter int GRANT_CYCLES = 6
) (
  // Clock, reset and inputs
  input wire logic                   sys_clk_i,
  input wire logic                   rst_i,
  input wire sdbc_pkg::sdbc_status_t status_i,
  input wire logic                   io_bus_mode_strap_i,
  input wire logic                   bus_grant_enable_n_i,
  input wire logic                   command_qualifier_i,
  // Outputs
  input wire logic [6:0]             cmd_o,
  input wire logic [1:0]             cmd_oe_o,
  input wire logic                   address_latch_strobe_o,
  input wire logic                   transceiver_enable_o,
  input wire logic                   transfer_direction_o,
  input wire logic                   cascade_or_periph_enable_o
);
  import sdbc_pkg::*;
  sdbc_cmd_t  c;
  logic [3:0] g_r, h_r, q_r, s_r;
  assign c = cmd_o;
  // Saturating run lengths; the inputs pass a two-flop synchroniser first.
  function automatic logic [3:0] sat(logic [3:0] n, logic k);
    return k ? n + 4'(n != 4'hf) : 4'h0;
  endfunction : sat
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      g_r <= 4'h0;
      h_r <= 4'h0;
      q_r <= 4'h0;
      s_r <= 4'h0;
    end else begin
      g_r <= sat(g_r, !bus_grant_enable_n_i);
      h_r <= sat(h_r, bus_grant_enable_n_i);
      q_r <= sat(q_r, !command_qualifier_i);
      s_r <= sat(s_r, io_bus_mode_strap_i);
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_pair(e, w);
    $fell(e) ##1 $fell(w);
  endsequence
  AST_ALE_ONCE: assert property (address_latch_strobe_o |=>
    !address_latch_strobe_o [*3]) else $error("latch strobe too long");
  AST_QUAL_IDLE: assert property (q_r >= 4 |->
    &cmd_o && !transceiver_enable_o) else $error("qualifier ignored");
  AST_DIR_WR: assert property (!(c.mem_write_strobe_n &&
    c.io_write_strobe_n) |-> transfer_direction_o) else $error("dir wr");
  AST_DIR_RD: assert property (!(c.mem_read_strobe_n &&
    c.io_read_strobe_n) |-> !transfer_direction_o) else $error("dir rd");
  AST_EARLY_MEM: assert property ($fell(c.early_mem_write_strobe_n) |->
    s_pair(c.early_mem_write_strobe_n, c.mem_write_strobe_n))
    else $error("early memory write order");
  AST_EARLY_IO: assert property ($fell(c.early_io_write_strobe_n) |->
    s_pair(c.early_io_write_strobe_n, c.io_write_strobe_n))
    else $error("early io write order");
  AST_GRANT_WAIT: assert property ($fell(&cmd_o) &&
    !io_bus_mode_strap_i |-> g_r >= GRANT_CYCLES) else $error("no wait");
  AST_FLOAT_MEM: assert property (h_r >= 4 |-> !cmd_oe_o[1])
    else $error("memory drivers kept on");
  AST_FLOAT_IO: assert property (h_r >= 4 && s_r == 0 &&
    !$past(io_bus_mode_strap_i, 3) |-> !cmd_oe_o[0]) else $error("io on");
  AST_IOB_IO: assert property (s_r >= 4 |-> cmd_oe_o[0])
    else $error("io drivers off in io bus mode");
  AST_CASCADE: assert property (cascade_or_periph_enable_o && s_r == 0 &&
    !$past(io_bus_mode_strap_i, 3) |-> address_latch_strobe_o)
    else $error("cascade without latch strobe");
  AST_DEN_LATE: assert property ($fell(transceiver_enable_o) |->
    &cmd_o && $past(&cmd_o)) else $error("enable dropped early");
endmodule : sdbc_bus_command_props

bind sdbc_bus_command sdbc_bus_command_props #(
  .GRANT_CYCLES(GRANT_CYCLES)
) u_props (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .status_i(status_i),
  .io_bus_mode_strap_i(io_bus_mode_strap_i),
  .bus_grant_enable_n_i(bus_grant_enable_n_i),
  .command_qualifier_i(command_qualifier_i),
  .cmd_o(cmd_o), .cmd_oe_o(cmd_oe_o),
  .address_latch_strobe_o(address_latch_strobe_o),
  .transceiver_enable_o(transceiver_enable_o),
  .transfer_direction_o(transfer_direction_o),
  .cascade_or_periph_enable_o(cascade_or_periph_enable_o)
);

// File: test/sdbc_cpu_model.sv
// Processor status pins and bus arbiter facing the block.
`timescale 1ns/1ps
module sdbc_cpu_model (
  // Clock
  input  wire logic              sys_clk_i,
  // Pins toward the block
  output sdbc_pkg::sdbc_status_t status_o,
  output logic                   grant_n_o
);
  import sdbc_pkg::*;
  initial begin
    status_o = SDBC_ST_PASSIVE;
    grant_n_o = 1'b0;
  end
  task automatic start(input logic [2:0] code);
    @(posedge sys_clk_i);
    status_o <= code;
  endtask : start
  // Released status lines sit at the pull-up level, the passive code.
  task automatic stop();
    @(posedge sys_clk_i);
    status_o <= SDBC_ST_PASSIVE;
  endtask : stop
  // Grant is given only while no other master holds the bus.
  task automatic arbitrate(input logic busy);
    @(posedge sys_clk_i);
    grant_n_o <= busy;
  endtask : arbitrate
endmodule : sdbc_cpu_model

// File: test/sdbc_bus_command_tb.sv
// Self-checking bench of the bus command block.
`timescale 1ns/1ps
module sdbc_bus_command_tb;
  import sdbc_pkg::*;
  localparam int GC = 6;
  localparam logic [6:0] EXP [7] =
    '{7'h7e, 7'h77, 7'h79, 7'h7f, 7'h3f, 7'h3f, 7'h4f};
  logic         sys_clk_i = 1'b0;
  logic         rst_i = 1'b1;
  sdbc_status_t status;
  logic         strap = 1'b0;
  logic         qual = 1'b1;
  logic         grant_n, ale, transceiver_enable, dir, cascade_address_enable;
  logic [6:0]   cmd;
  logic [1:0]   oe;
  int           bad_count = 0;
  int           samples_checked = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  sdbc_cpu_model cpu (.sys_clk_i(sys_clk_i), .status_o(status),
    .grant_n_o(grant_n));
  sdbc_bus_command #(.GRANT_CYCLES(GC)) dut (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .status_i(status), .io_bus_mode_strap_i(strap),
    .bus_grant_enable_n_i(grant_n), .command_qualifier_i(qual),
    .cmd_o(cmd), .cmd_oe_o(oe), .address_latch_strobe_o(ale),
    .transceiver_enable_o(transceiver_enable), .transfer_direction_o(dir),
    .cascade_or_periph_enable_o(cascade_address_enable));
  task automatic chk(input logic [6:0] g, input logic [6:0] e, string m);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick
  // One whole bus cycle, judged at the latch strobe and while strobes stand.
  task automatic cyc(input logic [2:0] c, input logic [6:0] e,
                     input logic d, input logic [1:0] o);
    cpu.start(c);
    tick(3);
    chk(7'(ale), 7'h01, "latch strobe");
    if (!strap) chk(7'(cascade_address_enable), 7'(c == 3'h0), "cascade");
    tick(2);
    chk(cmd, e, "strobes");
    chk(7'(transceiver_enable), 7'(d), "enable");
    chk(7'(dir), 7'(c == 3'h2 || c == 3'h6), "direction");
    chk(7'(oe), 7'(o), "driver enables");
    if (strap) chk(7'(cascade_address_enable), 7'(!(d && !c[2])), "periph enable");
    cpu.stop();
    tick(5);
    chk(cmd, 7'h7f, "release");
    chk(7'(transceiver_enable), 7'h00, "enable drop");
  endtask : cyc
  task automatic t_decode();
    cyc(3'h0, EXP[0], 1'b1, 2'b11);
    for (int i = 0; i < 7; i++) cyc(i[2:0], EXP[i], i != 3, 2'b11);
  endtask : t_decode
  task automatic t_qual();
    @(posedge sys_clk_i);
    qual <= 1'b0;
    tick(4);
    cyc(SDBC_ST_MEM_RD, 7'h7f, 1'b0, 2'b11);
    @(posedge sys_clk_i);
    qual <= 1'b1;
  endtask : t_qual
  task automatic t_grant();
    cpu.arbitrate(1'b1);
    cpu.start(SDBC_ST_MEM_RD);
    tick(5);
    chk(7'(oe), 7'h00, "float");
    cpu.arbitrate(1'b0);
    tick(4);
    chk(cmd, 7'h7f, "too early");
    tick(7);
    chk(cmd, 7'h3f, "granted read");
    cpu.stop();
    tick(5);
    chk(cmd, 7'h7f, "release after grant");
  endtask : t_grant
  task automatic t_iob();
    @(posedge sys_clk_i);
    strap <= 1'b1;
    cpu.arbitrate(1'b1);
    tick(4);
    cyc(SDBC_ST_IO_RD, EXP[1], 1'b1, 2'b01);
    cyc(SDBC_ST_IO_WR, EXP[2], 1'b1, 2'b01);
    cyc(SDBC_ST_MEM_RD, 7'h7f, 1'b0, 2'b01);
    cpu.arbitrate(1'b0);
    tick(8);
    cyc(SDBC_ST_MEM_RD, EXP[5], 1'b1, 2'b11);
  endtask : t_iob
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    tick(3);
    t_decode();
    t_qual();
    t_grant();
    t_iob();
    stop_test();
  end
  // The run needs some 210 clocks; a hang is cut off well beyond that.
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule : sdbc_bus_command_tb
